// ### shared/csp_link_if.sv
// carrier for edge counts and captured word from the link clock domain
`timescale 1ns/1ps
`default_nettype none
interface csp_link_if
  import csp_pkg::*;
  ();
  logic [CSP_GRAY_W-1:0]    rise_gray;
  logic [CSP_GRAY_W-1:0]    fall_gray;
  logic [CSP_WORD_BITS-1:0] word;

  modport link (output rise_gray, output fall_gray, output word);
  modport core (input rise_gray, input fall_gray, input word);
endinterface
`default_nettype wire

// ### shared/csp_pkg.sv
// shared constants, types and helpers for the code store serial access block
package csp_pkg;

  // store layout: security code in the low bits, configuration bits above it
  localparam int unsigned CSP_WORD_BITS = 31;
  localparam int unsigned CSP_CODE_BITS = 22;
  localparam int unsigned CSP_CFG_BITS  = 9;
  localparam int unsigned CSP_CFG_LSB   = 22;

  // link sequence counts
  localparam logic [2:0] CSP_RESET_PULSES = 3'h4;
  localparam logic [5:0] CSP_DATA_CLOCKS  = 6'h1f;
  localparam logic [4:0] CSP_POS_FIRST    = 5'h00;
  localparam logic [4:0] CSP_POS_LAST     = 5'h1e;

  // power-on sequence length in system clock periods
  localparam logic [2:0] CSP_POR_PERIODS = 3'h4;

  // system clock rate and the time one store write occupies
  localparam int unsigned CSP_CLK_MHZ      = 200;
  localparam int unsigned CSP_NVM_WRITE_NS = 100;
  localparam int unsigned CSP_NVM_WRITE_CYC =
    (CSP_NVM_WRITE_NS * CSP_CLK_MHZ + 999) / 1000;

  // width of the gray-coded edge counters crossing from the link clock
  localparam int unsigned CSP_GRAY_W = 4;
  localparam logic [CSP_GRAY_W-1:0] CSP_GRAY_ONE = 4'h1;
  localparam logic [CSP_GRAY_W-1:0] CSP_GRAY_ZERO = 4'h0;

  // session phase seen by the core
  typedef enum logic [1:0] {
    CSP_PH_OFF,
    CSP_PH_RESETS,
    CSP_PH_DATA
  } csp_phase_t;

  // store commit engine
  typedef enum logic {
    CSP_CM_IDLE,
    CSP_CM_WRITE
  } csp_commit_t;

  function automatic logic [CSP_GRAY_W-1:0] csp_bin2gray(input logic [CSP_GRAY_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CSP_GRAY_W-1:0] csp_gray2bin(input logic [CSP_GRAY_W-1:0] g);
    logic [CSP_GRAY_W-1:0] b;
    b = g;
    for (int i = CSP_GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ### sim/csp_station.sv
// programming station model: mode pin, clock pin, data and programming pulse
`timescale 1ns/1ps
`default_nettype none
module csp_station #(
  parameter int PH     = 4,
  parameter int SETTLE = 20
) (
  output var logic pin,
  output var logic mode,
  output var logic din,
  output var logic pp,
  input wire logic dout
);
  logic lclk = 1'b0;
  logic drv  = 1'b0;
  logic got[$];
  initial begin
    pin  = 1'b0;
    mode = 1'b0;
    din  = 1'b0;
    pp   = 1'b0;
  end
  // free grid for the station's own timing, phase unrelated to the core clock
  initial begin
    #2.3;
    forever #7.5 lclk = ~lclk;
  end
  // data line is not held outside its bit, so it never shows a stale level
  always @(negedge lclk) if (!drv) din <= ~din;
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // short clock burst, used while the core is held in reset and again after its release
  task automatic burst();
    repeat (4) begin
      pin <= 1'b1;
      tick(1);
      pin <= 1'b0;
      tick(1);
    end
  endtask
  // one pulse, data valid across the fall
  task automatic pulse(input logic b, input logic d);
    drv = d;
    if (d) din <= b;
    pin <= 1'b1;
    tick(PH);
    if (d) got.push_back(dout);
    pin <= 1'b0;
    tick(1);
    drv = 1'b0;
    tick(PH - 1);
  endtask
  // whole session with settle and hold times
  task automatic session(input int nres, input int ndata, input logic [30:0] w,
                         input bit prog);
    got.delete();
    mode <= 1'b1;
    tick(SETTLE);
    repeat (nres) pulse(1'b0, 1'b0);
    for (int k = 0; k < ndata; k++) pulse(w[k % 31], 1'b1);
    tick(2 * PH);
    if (prog) begin
      pp <= 1'b1;
      tick(PH);
      pp <= 1'b0;
      tick(20);
    end
    mode <= 1'b0;
    tick(PH);
  endtask
endmodule
`default_nettype wire

// ### sim/csp_top_asserts.sv
// concurrent checks on the ports of the code store access block
`timescale 1ns/1ps
`default_nettype none
module csp_top_asserts
  import csp_pkg::*;
#(
  parameter int unsigned WRITE_CYC = CSP_NVM_WRITE_CYC
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    osc_resistor_clock_pin,
  input wire logic                    osc_capacitor_mode_pin,
  input wire logic                    prog_pulse,
  input wire logic                    serial_in,
  input wire logic                    serial_out,
  input wire logic [CSP_CFG_BITS-1:0] cfg_bits,
  input wire logic                    por_done,
  input wire logic                    prog_refused,
  input wire logic                    commit_busy
);
  localparam int BUSY_MAX = WRITE_CYC + 8;
  logic [11:0] pin_h;
  logic [11:0] mode_h;
  logic [11:0] pp_h;
  // recent pin history; pins are async so the window allows sync slack
  always_ff @(posedge clk) begin
    pin_h  <= {pin_h[10:0], osc_resistor_clock_pin};
    mode_h <= {mode_h[10:0], osc_capacitor_mode_pin};
    pp_h   <= {pp_h[10:0], prog_pulse};
  end
  wire logic link_edge = (|(pin_h[10:0] ^ pin_h[11:1])) | (|(mode_h[10:0] ^ mode_h[11:1]));
  wire logic pp_rise   = |(pp_h[10:0] & ~pp_h[11:1]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_por_count: assert property ($fell(reset) |-> !por_done [*4] ##1 por_done)
    else $error("power-on end not four cycles after reset release");
  chk_por_hold: assert property (por_done |=> por_done)
    else $error("power-on done dropped without reset");
  chk_cfg_load: assert property ($changed(cfg_bits) |-> $rose(por_done))
    else $error("configuration bits changed outside power-on end");
  chk_ref_pulse: assert property (prog_refused |=> !prog_refused)
    else $error("refusal longer than one cycle");
  chk_ref_cause: assert property ($rose(prog_refused) |-> pp_rise)
    else $error("refusal without a programming pulse");
  chk_busy_cause: assert property ($rose(commit_busy) |-> pp_rise && !prog_refused)
    else $error("commit started without a valid programming pulse");
  chk_busy_bound: assert property ($rose(commit_busy) |-> ##[1:BUSY_MAX] !commit_busy)
    else $error("commit did not finish in time");
  chk_out_timing: assert property ($changed(serial_out) |-> link_edge)
    else $error("serial output moved without a link edge");

  cov_por: cover property ($rose(por_done));
  cov_commit: cover property ($rose(commit_busy));
  cov_refuse: cover property ($rose(prog_refused));
endmodule
bind csp_top csp_top_asserts #(.WRITE_CYC(WRITE_CYC)) u_chk (
  .clk(clk), .reset(reset), .osc_resistor_clock_pin(osc_resistor_clock_pin),
  .osc_capacitor_mode_pin(osc_capacitor_mode_pin), .prog_pulse(prog_pulse),
  .serial_in(serial_in), .serial_out(serial_out), .cfg_bits(cfg_bits),
  .por_done(por_done), .prog_refused(prog_refused), .commit_busy(commit_busy));
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the code store serial access block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import csp_pkg::*;
  // arbitrary contents of a never-programmed part
  localparam logic [30:0] FACT = 31'h2a5c_3b17;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  wire logic  pin, mode, din, pp, dout;
  logic [8:0] cfg;
  logic       por, refd, busy;
  logic       busy_q = 1'b0;
  logic [30:0] mem_m = FACT;
  logic [30:0] w;
  int error_cnt = 0;
  int checks = 0;
  int seed = 32'h5dee;
  int cyc = 0;
  int ref_cnt = 0;
  int com_cnt = 0;
  int r0, c0;
  int bad_nr[4] = '{4, 4, 3, 5};
  int bad_nd[4] = '{30, 32, 31, 31};
  always #2.5 clk = ~clk;
  csp_top #(.FACTORY_CODE(FACT), .WRITE_CYC(2)) dut (
    .clk(clk), .reset(reset), .osc_resistor_clock_pin(pin),
    .osc_capacitor_mode_pin(mode), .prog_pulse(pp), .serial_in(din),
    .serial_out(dout), .cfg_bits(cfg), .por_done(por), .prog_refused(refd),
    .commit_busy(busy));
  csp_station stn (.pin(pin), .mode(mode), .din(din), .pp(pp), .dout(dout));
  task automatic check(input logic [30:0] seen, input logic [30:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // counts of refusals and commit starts, and the hang limit
  always @(posedge clk) begin
    cyc++;
    busy_q <= busy;
    if (refd === 1'b1) ref_cnt++;
    if (busy === 1'b1 && busy_q !== 1'b1) com_cnt++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end
  // link pin must toggle during reset so the link side sees the reset too
  task automatic do_reset();
    @(negedge clk) reset <= 1'b1;
    stn.burst();
    repeat (5) @(negedge clk);
    reset <= 1'b0;
    repeat (6) @(negedge clk);
    check({30'h0, por}, 31'h1);
    check({22'h0, cfg}, {22'h0, mem_m[30:22]});
    // link side leaves reset only after two clock pin rises; flush it idle
    stn.burst();
  endtask
  task automatic read_cmp(input int n);
    for (int k = 0; k < n; k++) check({30'h0, stn.got[k]}, {30'h0, mem_m[k % 31]});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
    check({30'h0, busy}, 31'h0);
  endtask
  initial begin
    do_reset();
    // two groups back to back, with no reset pulses between them
    stn.session(4, 62, 31'h0, 1'b0);
    read_cmp(62);
    // valid program: old contents shown while shifting
    w = $random(seed);
    stn.session(4, 31, w, 1'b1);
    read_cmp(31);
    wait_idle();
    check(ref_cnt, 31'h0);
    check(com_cnt, 31'h1);
    mem_m = w;
    stn.session(4, 31, 31'h0, 1'b0);
    read_cmp(31);
    // wrong pulse counts are refused and leave the store alone
    for (int i = 0; i < 4; i++) begin
      r0 = ref_cnt;
      c0 = com_cnt;
      w = $random(seed);
      stn.session(bad_nr[i], bad_nd[i], w, 1'b1);
      wait_idle();
      check(ref_cnt - r0, 31'h1);
      check(com_cnt - c0, 31'h0);
    end
    stn.session(4, 31, 31'h0, 1'b0);
    read_cmp(31);
    // second reset reloads configuration from the programmed word
    do_reset();
    stn.session(4, 31, 31'h0, 1'b0);
    read_cmp(31);
    conclude();
  end
endmodule
`default_nettype wire

// ### verilog/csp_buf2.sv
// two-entry valid/ready buffer between capture and store commit
`timescale 1ns/1ps
`default_nettype none
module csp_buf2
  import csp_pkg::*;
#(
  parameter int unsigned WIDTH = CSP_WORD_BITS
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_q [2];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  // honest full and empty straight from the fill count
  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = slot_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, written by index
  always_ff @(posedge clk) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ### verilog/csp_link_cap.sv
// link clock domain: edge counters and serial input capture
`timescale 1ns/1ps
`default_nettype none
module csp_link_cap
  import csp_pkg::*;
(
  input  wire logic  link_clk,
  input  wire logic  reset,
  input  wire logic  serial_in,
  csp_link_if.link   lnk
);
  logic                     rst_s1_q;
  logic                     rst_s2_q;
  logic [CSP_GRAY_W-1:0]    rise_gray_q;
  logic [CSP_GRAY_W-1:0]    fall_gray_q;
  logic [CSP_WORD_BITS-1:0] word_q;

  // reset brought onto the link clock; needs link edges while asserted
  always_ff @(posedge link_clk) begin
    rst_s1_q <= reset;
    rst_s2_q <= rst_s1_q;
  end

  // rising edges, gray coded so the core can sample safely
  always_ff @(posedge link_clk) begin
    if (rst_s2_q) begin
      rise_gray_q <= CSP_GRAY_ZERO;
    end else begin
      rise_gray_q <= csp_bin2gray(csp_gray2bin(rise_gray_q) + CSP_GRAY_ONE);
    end
  end

  // falling edges counted the same way
  always_ff @(negedge link_clk) begin
    if (rst_s2_q) begin
      fall_gray_q <= CSP_GRAY_ZERO;
    end else begin
      fall_gray_q <= csp_bin2gray(csp_gray2bin(fall_gray_q) + CSP_GRAY_ONE);
    end
  end

  // falling edge capture
  // first bit shifted in ends in bit 0 after a full group
  always_ff @(negedge link_clk) begin
    word_q <= {serial_in, word_q[CSP_WORD_BITS-1:1]};
  end

  assign lnk.rise_gray = rise_gray_q;
  assign lnk.fall_gray = fall_gray_q;
  assign lnk.word      = word_q;
endmodule
`default_nettype wire

// ### verilog/csp_top.sv
// code store with serial read and program access over the clock pin
`timescale 1ns/1ps
`default_nettype none
module csp_top
  import csp_pkg::*;
#(
  // arbitrary contents for a never-programmed part
  parameter logic [CSP_WORD_BITS-1:0] FACTORY_CODE = 31'h2a5c_3b17,
  parameter int unsigned              WRITE_CYC    = CSP_NVM_WRITE_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    osc_resistor_clock_pin,
  input  wire logic                    osc_capacitor_mode_pin,
  input  wire logic                    prog_pulse,
  input  wire logic                    serial_in,
  output logic                         serial_out,
  output logic [CSP_CFG_BITS-1:0]      cfg_bits,
  output logic                         por_done,
  output logic                         prog_refused,
  output logic                         commit_busy
);
  csp_link_if lnk ();

  // link side: counters and capture run on the station's clock
  csp_link_cap u_link (
    .link_clk  (osc_resistor_clock_pin),
    .reset     (reset),
    .serial_in (serial_in),
    .lnk       (lnk.link)
  );

  // crossings into the system clock
  logic                     mode_s1_q;
  logic                     mode_s2_q;
  logic                     mode_prev_q;
  logic                     pulse_s1_q;
  logic                     pulse_s2_q;
  logic                     pulse_prev_q;
  logic [CSP_GRAY_W-1:0]    rise_s1_q;
  logic [CSP_GRAY_W-1:0]    rise_s2_q;
  logic [CSP_GRAY_W-1:0]    fall_s1_q;
  logic [CSP_GRAY_W-1:0]    fall_s2_q;
  logic [CSP_WORD_BITS-1:0] word_s1_q;
  logic [CSP_WORD_BITS-1:0] word_s2_q;

  // level pins through two flops before anything looks at them
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_s1_q  <= 1'b0;
      mode_s2_q  <= 1'b0;
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
    end else begin
      mode_s1_q  <= osc_capacitor_mode_pin;
      mode_s2_q  <= mode_s1_q;
      pulse_s1_q <= prog_pulse;
      pulse_s2_q <= pulse_s1_q;
    end
  end

  // gray counters cross as words; only one bit moves per link edge
  always_ff @(posedge clk) begin
    if (reset) begin
      rise_s1_q <= CSP_GRAY_ZERO;
      rise_s2_q <= CSP_GRAY_ZERO;
      fall_s1_q <= CSP_GRAY_ZERO;
      fall_s2_q <= CSP_GRAY_ZERO;
    end else begin
      rise_s1_q <= lnk.rise_gray;
      rise_s2_q <= rise_s1_q;
      fall_s1_q <= lnk.fall_gray;
      fall_s2_q <= fall_s1_q;
    end
  end

  // captured word is quasi-static: the clock pin sits low well before
  // the programming pulse, so this copy has long settled when read
  always_ff @(posedge clk) begin
    word_s1_q <= lnk.word;
    word_s2_q <= word_s1_q;
  end

  // edge history for the two synchronised levels
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_prev_q  <= 1'b0;
      pulse_prev_q <= 1'b0;
    end else begin
      mode_prev_q  <= mode_s2_q;
      pulse_prev_q <= pulse_s2_q;
    end
  end

  wire logic mode_rise  = mode_s2_q && !mode_prev_q;
  wire logic pulse_rise = pulse_s2_q && !pulse_prev_q;

  // link edge tracking: one rise and one fall retired per cycle at most, catching up if needed
  logic [CSP_GRAY_W-1:0] rise_seen_q;
  logic [CSP_GRAY_W-1:0] fall_seen_q;
  wire logic             rise_evt = mode_s2_q && (csp_gray2bin(rise_s2_q) != rise_seen_q);
  wire logic             fall_evt = mode_s2_q && (csp_gray2bin(fall_s2_q) != fall_seen_q);

  // edges that happen outside a session are simply absorbed
  always_ff @(posedge clk) begin
    if (reset) begin
      rise_seen_q <= CSP_GRAY_ZERO;
      fall_seen_q <= CSP_GRAY_ZERO;
    end else if (!mode_s2_q || mode_rise) begin
      rise_seen_q <= csp_gray2bin(rise_s2_q);
      fall_seen_q <= csp_gray2bin(fall_s2_q);
    end else begin
      if (rise_evt) begin
        rise_seen_q <= rise_seen_q + CSP_GRAY_ONE;
      end
      if (fall_evt) begin
        fall_seen_q <= fall_seen_q + CSP_GRAY_ONE;
      end
    end
  end

  // session sequencing: reset pulses, then data clocks
  csp_phase_t phase_q;
  logic [2:0] rst_cnt_q;
  logic [5:0] data_cnt_q;
  logic       over_q;
  logic [4:0] pos_q;
  logic       high_q;

  always_ff @(posedge clk) begin
    if (reset || !mode_s2_q) begin
      phase_q   <= CSP_PH_OFF;
      rst_cnt_q <= 3'h0;
    end else if (mode_rise) begin
      phase_q   <= CSP_PH_RESETS;
      rst_cnt_q <= 3'h0;
    end else if (fall_evt && phase_q == CSP_PH_RESETS) begin
      rst_cnt_q <= rst_cnt_q + 3'h1;
      if (rst_cnt_q == CSP_RESET_PULSES - 3'h1) begin
        phase_q <= CSP_PH_DATA;
      end
    end
  end

  // data clocks counted apart
  // overrun sticks until the mode pin drops or the core is reset
  always_ff @(posedge clk) begin
    if (reset || !mode_s2_q || mode_rise) begin
      data_cnt_q <= 6'h00;
      over_q     <= 1'b0;
    end else if (fall_evt && phase_q == CSP_PH_DATA) begin
      if (data_cnt_q == CSP_DATA_CLOCKS) begin
        over_q <= 1'b1;
      end else begin
        data_cnt_q <= data_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !mode_s2_q || mode_rise) begin
      pos_q <= CSP_POS_FIRST;
    end else if (fall_evt && phase_q == CSP_PH_DATA) begin
      pos_q <= (pos_q == CSP_POS_LAST) ? CSP_POS_FIRST : pos_q + 5'h01;
    end
  end

  // clock pin phase as last seen; a fall retired late still wins
  always_ff @(posedge clk) begin
    if (reset || !mode_s2_q || mode_rise) begin
      high_q <= 1'b0;
    end else if (fall_evt) begin
      high_q <= 1'b0;
    end else if (rise_evt) begin
      high_q <= 1'b1;
    end
  end

  // commit request: programming pulse after a clean sequence
  logic seq_valid;
  logic pend_q;
  logic refused_q;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [CSP_WORD_BITS-1:0] buf_out_data;

  assign seq_valid = (phase_q == CSP_PH_DATA) && (data_cnt_q == CSP_DATA_CLOCKS) && !over_q;

  // a held request waits for room in the buffer, it is never dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (pulse_rise && seq_valid) begin
      pend_q <= 1'b1;
    end else if (buf_in_ready) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= pulse_rise && !seq_valid;
    end
  end

  csp_buf2 #(.WIDTH (CSP_WORD_BITS)) u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (pend_q),
    .in_ready  (buf_in_ready),
    .in_data   (word_s2_q),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // nonvolatile store and its write engine
  csp_commit_t              cm_q;
  logic [15:0]              wr_timer_q;
  logic [CSP_WORD_BITS-1:0] wr_word_q;
  logic [CSP_WORD_BITS-1:0] store_q = FACTORY_CODE;

  // engine takes a word only when idle, so the buffer really fills
  assign buf_out_ready = (cm_q == CSP_CM_IDLE);

  // write occupies a fixed time, like a real cell program cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      cm_q       <= CSP_CM_IDLE;
      wr_timer_q <= 16'h0000;
      wr_word_q  <= '0;
    end else begin
      case (cm_q)
        CSP_CM_IDLE: begin
          if (buf_out_valid) begin
            cm_q       <= CSP_CM_WRITE;
            wr_word_q  <= buf_out_data;
            wr_timer_q <= 16'(WRITE_CYC - 1);
          end
        end
        CSP_CM_WRITE: begin
          if (wr_timer_q == 16'h0000) begin
            cm_q <= CSP_CM_IDLE;
          end else begin
            wr_timer_q <= wr_timer_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // 31-bit store, code low, config high
  // full word stored at the write's end
  // contents survive the system reset; the factory value is the power-up state
  always_ff @(posedge clk) begin
    if (cm_q == CSP_CM_WRITE && wr_timer_q == 16'h0000) begin
      store_q <= wr_word_q;
    end
  end

  // power-on sequence and configuration load
  logic [2:0]              por_cnt_q;
  logic                    por_done_q;
  logic [CSP_CFG_BITS-1:0] cfg_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      por_cnt_q  <= 3'h0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q <= por_cnt_q + 3'h1;
      if (por_cnt_q == CSP_POR_PERIODS - 3'h1) begin
        por_done_q <= 1'b1;
      end
    end
  end

  // configuration copied at power-on end
  // a later commit does not change the mode until the next power-on
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '0;
    end else if (!por_done_q && por_cnt_q == CSP_POR_PERIODS - 3'h1) begin
      cfg_q <= store_q[CSP_CFG_LSB +: CSP_CFG_BITS];
    end
  end

  // serial readout
  logic serial_out_q;

  // first bit on the rise, others on falls
  // always the stored word, never the one being shifted in
  always_ff @(posedge clk) begin
    if (reset || phase_q != CSP_PH_DATA) begin
      serial_out_q <= 1'b0;
    end else if (pos_q == CSP_POS_FIRST) begin
      serial_out_q <= high_q && !fall_evt ? store_q[pos_q] : 1'b0;
    end else begin
      serial_out_q <= store_q[pos_q];
    end
  end

  assign serial_out   = serial_out_q;
  assign cfg_bits     = cfg_q;
  assign por_done     = por_done_q;
  assign prog_refused = refused_q;
  assign commit_busy  = (cm_q == CSP_CM_WRITE) || buf_out_valid;
endmodule
`default_nettype wire
